//--- design/ccp_unit_consts.vh
// Constants for the two-channel capture/compare/pulse-width unit
`ifndef CCP_UNIT_CONSTS_VH
`define CCP_UNIT_CONSTS_VH

// Register byte addresses
`define ADDR_CH1_CONTROL 5'h00
`define ADDR_CH1_VALUE_LOW 5'h04
`define ADDR_CH1_VALUE_HIGH 5'h08
`define ADDR_CH2_CONTROL 5'h0C
`define ADDR_CH2_VALUE_LOW 5'h10
`define ADDR_CH2_VALUE_HIGH 5'h14
`define ADDR_EVENT_FLAGS 5'h18
`define ADDR_W 5

// Register select codes
`define SEL_CONTROL 2'h0
`define SEL_LOW 2'h1
`define SEL_HIGH 2'h2
`define SEL_FLAGS 2'h3

// Mode field codes
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'hA
`define MODE_CMP_TRIG 4'hB
`define GROUP_CAP 2'h1
`define GROUP_CMP 2'h2
`define GROUP_PWM 2'h3

// Control register fields
`define CTL_MODE_MSB 3
`define CTL_DUTY_MSB 5
`define CTL_DUTY_LSB 4
`define CTL_IMPL_MASK 8'h3F

// Prescaler terminal counts
`define PSC_LAST4 4'h3
`define PSC_LAST16 4'hF

// Reset values
`define RST_CONTROL 8'h00
`define RST_VALUE 8'h00
`define RST_FLAGS 2'h0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/ccp_unit.v
// Two-channel capture/compare/pulse-width unit with an AXI4-Lite register slave
// Operation
// - Mode 0000 disables and resets a channel; mode 11xx selects pulse-width mode.
// - Capture on falling, rising, every fourth or every sixteenth rising edge by mode.
// - Compare 1000 drives output high, 1001 low on match; both set flag.
// - Compare 1010 only sets the flag on match; pin stays unchanged.
// - Compare 1011 sets flag, resets timer A; channel two also starts conversion.
// - Control bits 5:4 are duty low bits in pulse-width mode only.
// - Control bits 7:6 read as zero.
// - A capture event copies the full 16-bit timer A count into the value pair.
// - Every capture sets the channel flag; it stays until software clears it.
// - A newer capture overwrites an unread stored value.
// - Port latch writes that change an output pin count as capture events.
// - Mode changes may raise a spurious flag; software masks, then clears it.
// - Prescaler counter clears when disabled, outside capture mode, and on reset.
// - Direct prescale switches keep the counter; software writes zero first.
// - Compare checks value against timer A continuously; match acts and flags together.
// - Zero written to control forces the compare output latch low.
// - Special-event timer A reset never sets the timer A overflow flag.
// - Pulse-width output has 10-bit duty; cleared control forces it low.
// - Capture and compare use timer A; pulse-width uses timer B.
// - At period match the next increment sets pin unless duty zero and reloads duty.
// - Pin clears when buffered 10-bit duty equals timer B with two sub-count bits.
// - A software write to timer A beats a coincident special-event reset.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_unit_consts.vh"

module ccp_unit
(
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // AXI4-Lite write address and data
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    // Channel pins, as seen at the pad
    input wire [1:0] chan_pin,
    // Shared timer A
    input wire [15:0] shared_timer_a,
    input wire timer_a_write,
    output wire timer_a_reset,
    // Shared timer B
    input wire [7:0] shared_timer_b,
    input wire [7:0] timer_b_period,
    input wire [1:0] timer_b_sub,
    input wire timer_b_inc,
    // Converter
    input wire adc_enable,
    output wire adc_start,
    // Channel outputs and flags
    output wire [1:0] chan_out,
    output wire [1:0] chan_event_flag
);

    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n;

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // Decode: bit 2 = channel, bits 1:0 = register, bit 3 = valid
    function [3:0] reg_sel;
        input [`ADDR_W-1:0] a;
        begin
            case (a)
                `ADDR_CH1_CONTROL: reg_sel = {1'b1, 1'b0, `SEL_CONTROL};
                `ADDR_CH1_VALUE_LOW: reg_sel = {1'b1, 1'b0, `SEL_LOW};
                `ADDR_CH1_VALUE_HIGH: reg_sel = {1'b1, 1'b0, `SEL_HIGH};
                `ADDR_CH2_CONTROL: reg_sel = {1'b1, 1'b1, `SEL_CONTROL};
                `ADDR_CH2_VALUE_LOW: reg_sel = {1'b1, 1'b1, `SEL_LOW};
                `ADDR_CH2_VALUE_HIGH: reg_sel = {1'b1, 1'b1, `SEL_HIGH};
                `ADDR_EVENT_FLAGS: reg_sel = {1'b1, 1'b0, `SEL_FLAGS};
                default: reg_sel = 4'h0;
            endcase
        end
    endfunction

    // Write channel: address and data may arrive in either order
    reg awready_r;
    reg wready_r;
    reg aw_full_r;
    reg w_full_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg [`ADDR_W-1:0] waddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    wire [3:0] wsel;
    wire wr_go;

    assign wsel = reg_sel(waddr_r);
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            waddr_r <= {`ADDR_W{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_r)
            begin
                waddr_r <= s_axi_awaddr;
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_go)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wsel[3] ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Registers are one byte wide, so only lane 0 is honoured
    wire wr_lane0;
    assign wr_lane0 = wr_go && wsel[3] && wstrb_r[0];

    // Channels
    wire [1:0] ch_event;
    wire [1:0] ch_trig;
    wire [7:0] ch_ctl [0:1];
    wire [7:0] ch_low [0:1];
    wire [7:0] ch_high [0:1];
    wire [1:0] ch_out;
    // Time base one step ahead, so the registered pin falls as the count reaches the duty value
    wire [9:0] pwm_time_ahead;

    assign pwm_time_ahead = {shared_timer_b, timer_b_sub} + 10'h001;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : gen_ch
            reg [7:0] ctl_r;
            reg [7:0] low_r;
            reg [7:0] high_r;
            reg [1:0] duty_lat_r;
            reg [3:0] psc_r;
            reg pin_d_r;
            reg out_r;
            reg match_d_r;
            wire [3:0] mode;
            wire is_cap;
            wire is_cmp;
            wire is_pwm;
            wire rise;
            wire fall;
            wire psc_hit;
            wire cap_ev;
            wire match;
            wire wr_ch;
            wire period_end;
            wire [9:0] duty_new;

            assign mode = ctl_r[`CTL_MODE_MSB:0];
            assign is_cap = mode[3:2] == `GROUP_CAP;
            assign is_cmp = mode[3:2] == `GROUP_CMP;
            assign is_pwm = mode[3:2] == `GROUP_PWM;
            // The pad level includes the port latch drive, so a latch write that
            // flips an output pin shows up here as an edge
            assign rise = chan_pin[gi] && !pin_d_r;
            assign fall = !chan_pin[gi] && pin_d_r;
            assign psc_hit = (mode == `MODE_CAP_RISE4) ? (psc_r == `PSC_LAST4) : (psc_r == `PSC_LAST16);
            assign cap_ev = is_cap && ((mode == `MODE_CAP_FALL) ? fall :
                (mode == `MODE_CAP_RISE) ? rise : (rise && psc_hit));
            assign match = is_cmp && ({high_r, low_r} == shared_timer_a);
            // Only the first cycle of a match fires, so a stalled timer gives one pulse
            assign ch_trig[gi] = match && !match_d_r && (mode == `MODE_CMP_TRIG);
            assign ch_event[gi] = cap_ev || match;
            assign wr_ch = wr_lane0 && (wsel[2] == gi) && (wsel[1:0] != `SEL_FLAGS);
            assign period_end = is_pwm && timer_b_inc && (shared_timer_b == timer_b_period);
            assign duty_new = {low_r, ctl_r[`CTL_DUTY_MSB:`CTL_DUTY_LSB]};
            assign ch_ctl[gi] = ctl_r & `CTL_IMPL_MASK;
            assign ch_low[gi] = low_r;
            assign ch_high[gi] = high_r;
            assign ch_out[gi] = out_r;

            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ctl_r <= `RST_CONTROL;
                    low_r <= `RST_VALUE;
                    high_r <= `RST_VALUE;
                    duty_lat_r <= 2'h0;
                    psc_r <= 4'h0;
                    pin_d_r <= 1'b0;
                    out_r <= 1'b0;
                    match_d_r <= 1'b0;
                end
                else
                begin
                    pin_d_r <= chan_pin[gi];
                    match_d_r <= match;
                    if (wr_ch && wsel[1:0] == `SEL_CONTROL)
                        ctl_r <= wdata_r[7:0] & `CTL_IMPL_MASK;
                    // Prescaler survives direct switches between capture modes
                    if (!is_cap)
                        psc_r <= 4'h0;
                    else if (rise && (mode == `MODE_CAP_RISE4 || mode == `MODE_CAP_RISE16))
                        psc_r <= psc_hit ? 4'h0 : psc_r + 4'h1;
                    // Capture wins over a coincident bus write
                    if (cap_ev)
                    begin
                        low_r <= shared_timer_a[7:0];
                        high_r <= shared_timer_a[15:8];
                    end
                    else
                    begin
                        if (wr_ch && wsel[1:0] == `SEL_LOW)
                            low_r <= wdata_r[7:0];
                        if (period_end)
                            high_r <= low_r;
                        else if (wr_ch && wsel[1:0] == `SEL_HIGH && !is_pwm)
                            high_r <= wdata_r[7:0];
                    end
                    if (period_end)
                        duty_lat_r <= ctl_r[`CTL_DUTY_MSB:`CTL_DUTY_LSB];
                    // Output latch
                    if (mode == `MODE_OFF)
                        out_r <= 1'b0;
                    else if (match && mode == `MODE_CMP_SET)
                        out_r <= 1'b1;
                    else if (match && mode == `MODE_CMP_CLEAR)
                        out_r <= 1'b0;
                    else if (period_end)
                        out_r <= (duty_new != 10'h000);
                    else if (is_pwm && ({high_r, duty_lat_r} == pwm_time_ahead))
                        out_r <= 1'b0;
                    else if (!is_cmp && !is_pwm)
                        out_r <= 1'b0;
                end
            end
        end
    endgenerate

    // Event flags: hardware set beats a software clear in the same cycle
    reg [1:0] flag_r;
    wire [1:0] flag_clr;

    assign flag_clr = (wr_lane0 && wsel[1:0] == `SEL_FLAGS) ? wdata_r[1:0] : 2'h0;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= `RST_FLAGS;
        else
            flag_r <= (flag_r & ~flag_clr) | ch_event;
    end

    // Special-event outputs; these never touch any overflow flag
    reg tmr_rst_r;
    reg adc_start_r;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmr_rst_r <= 1'b0;
            adc_start_r <= 1'b0;
        end
        else
        begin
            tmr_rst_r <= (ch_trig[0] || ch_trig[1]) && !timer_a_write;
            adc_start_r <= ch_trig[1] && adc_enable;
        end
    end

    // Read channel
    reg arready_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;
    reg [7:0] rd_byte;
    wire [3:0] rsel;

    assign rsel = reg_sel(s_axi_araddr);

    always @*
    begin
        case (rsel[1:0])
            `SEL_CONTROL: rd_byte = ch_ctl[rsel[2]];
            `SEL_LOW: rd_byte = ch_low[rsel[2]];
            `SEL_HIGH: rd_byte = ch_high[rsel[2]];
            default: rd_byte = {6'h00, flag_r};
        endcase
    end

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rsel[3] ? {24'h000000, rd_byte} : 32'h00000000;
            rresp_r <= rsel[3] ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign timer_a_reset = tmr_rst_r;
    assign adc_start = adc_start_r;
    assign chan_out = ch_out;
    assign chan_event_flag = flag_r;

endmodule // ccp_unit

`default_nettype wire

//--- bench/ccp_unit_properties.sv
// Port-level assertions for the capture/compare/pulse-width unit
`timescale 1ns/1ps
`default_nettype none
`include "ccp_unit_consts.vh"
module ccp_unit_properties
(
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_bvalid,
    input wire s_axi_rvalid,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire [31:0] s_axi_rdata,
    // Timer, converter and channel side
    input wire timer_a_write,
    input wire timer_a_reset,
    input wire adc_start,
    input wire [1:0] chan_out,
    input wire [1:0] chan_event_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Only catches writes whose address and data are taken together
    wire clr1 = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
        s_axi_awaddr == `ADDR_CH1_CONTROL && s_axi_wstrb[0] && s_axi_wdata[7:0] == 8'h00;
    AST_TRIG_ONE_WIDE: assert property (timer_a_reset |=> !timer_a_reset)
        else $error("timer reset pulse too wide");
    AST_ADC_ONE_WIDE: assert property (adc_start |=> !adc_start)
        else $error("converter start too wide");
    AST_ADC_WITH_TRIG: assert property (adc_start |-> timer_a_reset)
        else $error("converter start without timer reset");
    AST_WRITE_WINS: assert property (timer_a_write [*3] |-> !timer_a_reset)
        else $error("timer reset during timer write");
    AST_TRIG_FLAGGED: assert property (timer_a_reset |-> chan_event_flag != 2'h0)
        else $error("trigger without channel flag");
    AST_CTL_TOP_ZERO: assert property ($rose(s_axi_rvalid) && ($past(s_axi_araddr) == `ADDR_CH1_CONTROL ||
        $past(s_axi_araddr) == `ADDR_CH2_CONTROL) |-> s_axi_rdata[7:6] == 2'h0)
        else $error("control bits 7:6 not zero");
    AST_FLAG1_HOLD: assert property ($fell(chan_event_flag[0]) |-> $rose(s_axi_bvalid))
        else $error("flag 1 dropped without a write");
    AST_FLAG2_HOLD: assert property ($fell(chan_event_flag[1]) |-> $rose(s_axi_bvalid))
        else $error("flag 2 dropped without a write");
    AST_OUT_OFF_CLEARED: assert property (clr1 |-> ##[2:3] !chan_out[0])
        else $error("output latch not low after control clear");
endmodule // ccp_unit_properties
bind ccp_unit ccp_unit_properties ccp_unit_properties_inst (.*);
`default_nettype wire

//--- bench/ccp_far_side.sv
// Pads and time bases that stand around the unit
`timescale 1ns/1ps
`default_nettype none
module ccp_far_side
(
    // Clock, reset and bench controls
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run_a,
    input wire logic [1:0] pin_req,
    input wire logic [7:0] timer_b_period,
    // Trigger from the unit
    input wire logic timer_a_reset,
    // Pads and time bases
    output logic [1:0] chan_pin,
    output logic [15:0] shared_timer_a,
    output logic [7:0] shared_timer_b,
    output logic [1:0] timer_b_sub,
    output logic timer_b_inc
);
    assign chan_pin = pin_req;
    assign timer_b_inc = (timer_b_sub == 2'h3);
    // Timer A runs on the same clock, never as a free-running asynchronous counter
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            shared_timer_a <= 16'h0000;
            shared_timer_b <= 8'h00;
            timer_b_sub <= 2'h0;
        end
        else
        begin
            if (timer_a_reset)
                shared_timer_a <= 16'h0000;
            else if (run_a)
                shared_timer_a <= shared_timer_a + 16'h0001;
            timer_b_sub <= timer_b_sub + 2'h1;
            if (timer_b_inc)
                shared_timer_b <= (shared_timer_b == timer_b_period) ? 8'h00 : shared_timer_b + 8'h01;
        end
    end
endmodule // ccp_far_side
`default_nettype wire

//--- bench/testbench.sv
// Register-level tests of the capture/compare/pulse-width unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, chan_pin, timer_b_sub, chan_out, chan_event_flag;
    wire [31:0] s_axi_rdata;
    logic timer_a_write, adc_enable, run_a;
    logic [1:0] pin_req, rsp;
    logic [7:0] timer_b_period;
    wire [15:0] shared_timer_a;
    wire [7:0] shared_timer_b;
    wire timer_b_inc, timer_a_reset, adc_start;
    int fail_count = 0, cmp_count = 0, cyc = 0, n_trg = 0, n_adc = 0, n, i, k;
    logic [15:0] v;
    logic [7:0] cm[5] = '{8'h08, 8'h0A, 8'h09, 8'h08, 8'h00};
    logic co[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    ccp_unit ccp_unit_inst (.*);
    ccp_far_side ccp_far_side_inst (.*);
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        begin
            cmp_count++;
            if (s !== e)
            begin
                $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
                fail_count++;
            end
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            do
            begin
                @(posedge mclk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            end
            while (s_axi_bvalid !== 1'b1);
            rsp = s_axi_bresp;
        end
    endtask
    task automatic rd(input logic [4:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do
            begin
                @(posedge mclk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            end
            while (s_axi_rvalid !== 1'b1);
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
        end
    endtask
    task automatic pulse;
        begin
            pin_req[0] <= 1'b1;
            repeat (3) @(posedge mclk);
            pin_req[0] <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    task automatic freeze;
        begin
            run_a <= 1'b1;
            repeat (9) @(posedge mclk);
            run_a <= 1'b0;
            @(posedge mclk);
            v = shared_timer_a;
        end
    endtask
    task automatic pwm(input logic [7:0] lo, input logic [7:0] ctl, input int e);
        begin
            wr(5'h04, lo);
            wr(5'h00, ctl);
            repeat (40) @(posedge mclk);
            n = 0;
            repeat (64)
            begin
                @(posedge mclk);
                if (chan_out[0] === 1'b1) n++;
            end
            chk(n, e);
        end
    endtask
    task end_sim;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Hang guard sized well above the fewer than one thousand cycles the tests need
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (timer_a_reset === 1'b1) n_trg <= n_trg + 1;
        if (adc_start === 1'b1) n_adc <= n_adc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim;
        end
    end
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, timer_a_write, adc_enable, run_a} = 6'h00;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = 48'h0;
        pin_req = 2'h0;
        timer_b_period = 8'h03;
        rstn = 1'b0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (i = 0; i < 7; i++)
        begin
            rd(5'(i * 4));
            chk(rdv, 0);
        end
        rd(5'h1C);
        chk(rsp, 2);
        $display("reset and map test done");
        for (i = 0; i < 4; i++)
        begin
            wr(5'h00, 8'h00);
            freeze;
            wr(5'h00, 8'hF4 + i[7:0]);
            wr(5'h18, 8'h01);
            rd(5'h00);
            chk(rdv, 32'h34 + i);
            n = (i < 2) ? 1 : ((i == 2) ? 4 : 16);
            repeat (n - 1) pulse;
            rd(5'h18);
            chk(rdv, 0);
            pulse;
            rd(5'h18);
            chk(rdv, 1);
            rd(5'h04);
            chk(rdv, v[7:0]);
            rd(5'h08);
            chk(rdv, v[15:8]);
        end
        wr(5'h00, 8'h00);
        wr(5'h00, 8'h05);
        pulse;
        freeze;
        pulse;
        rd(5'h04);
        chk(rdv, v[7:0]);
        rd(5'h08);
        chk(rdv, v[15:8]);
        $display("capture test done");
        wr(5'h00, 8'h00);
        wr(5'h04, v[7:0]);
        wr(5'h08, v[15:8]);
        wr(5'h18, 8'h01);
        chk(rsp, 0);
        for (i = 0; i < 5; i++)
        begin
            wr(5'h00, cm[i]);
            repeat (3) @(posedge mclk);
            chk(chan_out[0], co[i]);
        end
        rd(5'h18);
        chk(rdv, 1);
        $display("compare test done");
        v = v + 16'h0020;
        wr(5'h10, v[7:0]);
        wr(5'h14, v[15:8]);
        adc_enable <= 1'b1;
        wr(5'h0C, 8'h0B);
        k = n_trg;
        run_a <= 1'b1;
        repeat (60) @(posedge mclk);
        chk(n_trg - k, 1);
        chk(n_adc, 1);
        rd(5'h18);
        chk(rdv, 3);
        wr(5'h0C, 8'h00);
        timer_a_write <= 1'b1;
        wr(5'h00, 8'h0B);
        repeat (100) @(posedge mclk);
        timer_a_write <= 1'b0;
        wr(5'h00, 8'h00);
        chk(n_trg - k, 1);
        $display("special event test done");
        pwm(8'h01, 8'h2C, 24);
        pwm(8'h00, 8'h0C, 0);
        wr(5'h00, 8'h00);
        repeat (3) @(posedge mclk);
        chk(chan_out, 0);
        $display("pulse-width test done");
        freeze;
        wr(5'h00, 8'h05);
        pulse;
        rd(5'h04);
        chk(rdv, v[7:0]);
        rd(5'h08);
        chk(rdv, v[15:8]);
        $display("wide capture test done");
        end_sim;
    end
endmodule // testbench
`default_nettype wire
